// >>> design/sbow_pkg.sv
package sbow_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (word addresses on the register port)
  // ---------------------------------------------------------------------------
  localparam logic [6:0] OFS_ACCEL_BOW_FIRST  = 7'h2d;
  localparam logic [6:0] OFS_ACCEL_BOW_SECOND = 7'h2e;
  localparam logic [6:0] OFS_DECEL_BOW_FIRST  = 7'h2f;
  localparam logic [6:0] OFS_DECEL_BOW_SECOND = 7'h30;
  localparam logic [6:0] OFS_EXT_CLOCK_HERTZ  = 7'h31;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int          BOW_W         = 24;
  localparam int          CLK_W         = 25;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 32;
  localparam logic [23:0] BOW_RESET     = 24'h000000;
  localparam logic [24:0] CLK_HZ_RESET  = 25'h0f42400;

  // ---------------------------------------------------------------------------
  // Conversion arithmetic
  // ---------------------------------------------------------------------------
  // Direct values are jerk steps in units of 2^-53 of acceleration per cycle
  localparam int          BOW_FRAC_BITS = 53;
  localparam int          NUM_W         = BOW_W + BOW_FRAC_BITS;
  localparam logic [6:0]  DIV_STEPS     = 7'h4d;

  // Conversion sequencer: one pass of the divider per power of the clock rate
  typedef enum logic [1:0] {
    SBOW_LOAD = 2'b00,
    SBOW_DIV1 = 2'b01,
    SBOW_DIV2 = 2'b10,
    SBOW_DIV3 = 2'b11
  } sbow_conv_e;

endpackage

// >>> design/sbow_divider.sv
`timescale 1ns/10ps
module sbow_divider (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_start,
  input  wire logic [sbow_pkg::NUM_W-1:0]     i_dividend,
  input  wire logic [sbow_pkg::CLK_W-1:0]     i_divisor,
  output logic                                o_done,
  output logic      [sbow_pkg::NUM_W-1:0]     o_quot
);

  typedef struct packed {
    logic [sbow_pkg::NUM_W-1:0] quot;
    logic [sbow_pkg::CLK_W-1:0] rem;
    logic [sbow_pkg::CLK_W-1:0] dvs;
    logic [6:0]                 cnt;
    logic                       busy;
    logic                       done;
  } sbow_div_s;

  sbow_div_s state_q;
  sbow_div_s state_d;
  logic [sbow_pkg::CLK_W:0] trial;

  // ---------------------------------------------------------------------------
  // Restoring division, one quotient bit per cycle
  // ---------------------------------------------------------------------------
  // Serial to keep the area small; a zero divisor yields an all-ones quotient
  always_comb begin
    state_d      = state_q;
    state_d.done = 1'b0;
    trial        = {state_q.rem, state_q.quot[sbow_pkg::NUM_W-1]};
    if (i_start) begin
      state_d.quot = i_dividend;
      state_d.rem  = '0;
      state_d.dvs  = i_divisor;
      state_d.cnt  = sbow_pkg::DIV_STEPS;
      state_d.busy = 1'b1;
    end else if (state_q.busy) begin
      if (trial >= {1'b0, state_q.dvs}) begin
        trial = trial - {1'b0, state_q.dvs};
        state_d.quot = {state_q.quot[sbow_pkg::NUM_W-2:0], 1'b1};
      end else begin
        state_d.quot = {state_q.quot[sbow_pkg::NUM_W-2:0], 1'b0};
      end
      state_d.rem = trial[sbow_pkg::CLK_W-1:0];
      state_d.cnt = state_q.cnt - 7'h01;
      if (state_q.cnt == 7'h01) begin
        state_d.busy = 1'b0;
        state_d.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_done = state_q.done;
  assign o_quot = state_q.quot;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [sbow_pkg::NUM_W-1:0] dvd_h;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dvd_h <= '0;
    end else if (i_start) begin
      dvd_h <= i_dividend;
    end
  end

  div_exact_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_done && state_q.dvs != '0) |->
      ({25'h0, o_quot} * {77'h0, state_q.dvs} + {77'h0, state_q.rem} == {25'h0, dvd_h}))
    else $error("divider result does not reproduce the dividend");

  div_time_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_start && !state_q.busy) |-> ##78 o_done)
    else $error("divider did not finish in 78 cycles");

  div_done_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_done);

endmodule

// >>> design/sbow_regs.sv
// Functional notes
// - The 24-bit unsigned first acceleration bow sets the opening acceleration jerk.
// - The 24-bit unsigned second acceleration bow sets the closing acceleration jerk.
// - The 24-bit unsigned first deceleration bow sets the opening deceleration jerk.
// - The 24-bit unsigned second deceleration bow sets the closing deceleration jerk.
// - In frequency form a bow is whole pulses per second cubed, valid from 1 to 16 M.
// - In direct form the bow over 2^53 is added to the acceleration every cycle.
// - Direct-form jerk per second cubed equals the bow over 2^53 times the clock rate cubed.
// - The clock rate register holds the clock in hertz, 25 bits unsigned, 4.2 to 32 MHz.
`timescale 1ns/10ps
module sbow_regs (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_wr_en,
  input  wire logic                          i_rd_en,
  input  wire logic [sbow_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [sbow_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                          i_direct_mode,
  input  wire logic [1:0]                    i_bow_sel,
  output logic      [sbow_pkg::DATA_W-1:0]   o_rdata,
  output logic                               o_rd_valid,
  output logic      [sbow_pkg::BOW_W-1:0]    o_jerk_inc,
  output logic                               o_conv_valid
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0][sbow_pkg::BOW_W-1:0] bow;
    logic [sbow_pkg::CLK_W-1:0]      clk_hz;
    logic [3:0][sbow_pkg::BOW_W-1:0] conv;
    sbow_pkg::sbow_conv_e            st;
    logic [1:0]                      idx;
    logic [sbow_pkg::NUM_W-1:0]      num;
    logic [sbow_pkg::CLK_W-1:0]      f_snap;
    logic                            start;
    logic                            dirty;
    logic                            conv_valid;
    logic [sbow_pkg::DATA_W-1:0]     rdata;
    logic                            rvalid;
    logic [sbow_pkg::BOW_W-1:0]      jerk;
  } sbow_state_s;

  sbow_state_s                   state_q;
  sbow_state_s                   state_d;
  logic                          div_done;
  logic [sbow_pkg::NUM_W-1:0]    div_quot;
  logic [2:0]                    wr_hit;
  logic [2:0]                    rd_hit;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Returns {hit, index} for the four bow registers
  function automatic logic [2:0] bow_decode(input logic [sbow_pkg::ADDR_W-1:0] addr);
    logic [2:0] res;
    res = 3'h0;
    unique case (addr)
      sbow_pkg::OFS_ACCEL_BOW_FIRST:  res = 3'h4;
      sbow_pkg::OFS_ACCEL_BOW_SECOND: res = 3'h5;
      sbow_pkg::OFS_DECEL_BOW_FIRST:  res = 3'h6;
      sbow_pkg::OFS_DECEL_BOW_SECOND: res = 3'h7;
      default:                        res = 3'h0;
    endcase
    return res;
  endfunction

  // Quotients too large for the bow field are clipped, never wrapped
  function automatic logic [sbow_pkg::BOW_W-1:0] saturate(
    input logic [sbow_pkg::NUM_W-1:0] val
  );
    logic [sbow_pkg::BOW_W-1:0] res;
    res = val[sbow_pkg::BOW_W-1:0];
    if (|val[sbow_pkg::NUM_W-1:sbow_pkg::BOW_W]) begin
      res = '1;
    end
    return res;
  endfunction

  assign wr_hit = bow_decode(i_addr);
  assign rd_hit = bow_decode(i_addr);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d        = state_q;
    state_d.start  = 1'b0;
    state_d.rvalid = 1'b0;

    // Jerk step for the bow the ramp sequencer is in
    if (i_direct_mode) begin
      state_d.jerk = state_q.bow[i_bow_sel];
    end else begin
      state_d.jerk = state_q.conv[i_bow_sel];
    end

    // Round-robin conversion of each bow: field * 2^53 / f / f / f
    unique case (state_q.st)
      sbow_pkg::SBOW_LOAD: begin
        state_d.num    = {state_q.bow[state_q.idx], 53'h0};
        state_d.f_snap = state_q.clk_hz;
        state_d.start  = 1'b1;
        state_d.st     = sbow_pkg::SBOW_DIV1;
      end
      sbow_pkg::SBOW_DIV1: begin
        if (div_done) begin
          state_d.num   = div_quot;
          state_d.start = 1'b1;
          state_d.st    = sbow_pkg::SBOW_DIV2;
        end
      end
      sbow_pkg::SBOW_DIV2: begin
        if (div_done) begin
          state_d.num   = div_quot;
          state_d.start = 1'b1;
          state_d.st    = sbow_pkg::SBOW_DIV3;
        end
      end
      sbow_pkg::SBOW_DIV3: begin
        if (div_done) begin
          state_d.conv[state_q.idx] = saturate(div_quot);
          state_d.idx               = state_q.idx + 2'h1;
          state_d.st                = sbow_pkg::SBOW_LOAD;
          if (state_q.idx == 2'h3) begin
            state_d.conv_valid = ~state_q.dirty;
            state_d.dirty      = 1'b0;
          end
        end
      end
    endcase

    // Register writes; a write mid-round marks that round stale
    if (i_wr_en) begin
      if (wr_hit[2]) begin
        state_d.bow[wr_hit[1:0]] = i_wdata[sbow_pkg::BOW_W-1:0];
        state_d.dirty            = 1'b1;
        state_d.conv_valid       = 1'b0;
      end else if (i_addr == sbow_pkg::OFS_EXT_CLOCK_HERTZ) begin
        state_d.clk_hz     = i_wdata[sbow_pkg::CLK_W-1:0];
        state_d.dirty      = 1'b1;
        state_d.conv_valid = 1'b0;
      end
    end

    // Register reads; unmapped offsets and upper bits read as zero
    if (i_rd_en) begin
      state_d.rvalid = 1'b1;
      state_d.rdata  = '0;
      if (rd_hit[2]) begin
        state_d.rdata = {8'h00, state_q.bow[rd_hit[1:0]]};
      end else if (i_addr == sbow_pkg::OFS_EXT_CLOCK_HERTZ) begin
        state_d.rdata = {7'h00, state_q.clk_hz};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q        <= '0;
      state_q.bow    <= {4{sbow_pkg::BOW_RESET}};
      state_q.clk_hz <= sbow_pkg::CLK_HZ_RESET;
      state_q.f_snap <= sbow_pkg::CLK_HZ_RESET;
      state_q.st     <= sbow_pkg::SBOW_LOAD;
      state_q.dirty  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared serial divider; three passes per bow keep the product width down
  sbow_divider u_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (state_q.start),
    .i_dividend (state_q.num),
    .i_divisor  (state_q.f_snap),
    .o_done     (div_done),
    .o_quot     (div_quot)
  );

  assign o_rdata      = state_q.rdata;
  assign o_rd_valid   = state_q.rvalid;
  assign o_jerk_inc   = state_q.jerk;
  assign o_conv_valid = state_q.conv_valid;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  accel_open_a: assert property (
    (!i_direct_mode && i_bow_sel == 2'h0) |=> o_jerk_inc == $past(state_q.conv[0]))
    else $error("opening acceleration bow step wrong");

  accel_close_a: assert property (
    (!i_direct_mode && i_bow_sel == 2'h1) |=> o_jerk_inc == $past(state_q.conv[1]))
    else $error("closing acceleration bow step wrong");

  decel_open_a: assert property (
    (!i_direct_mode && i_bow_sel == 2'h2) |=> o_jerk_inc == $past(state_q.conv[2]))
    else $error("opening deceleration bow step wrong");

  decel_close_a: assert property (
    (!i_direct_mode && i_bow_sel == 2'h3) |=> o_jerk_inc == $past(state_q.conv[3]))
    else $error("closing deceleration bow step wrong");

  bow_store_a: assert property (
    (i_wr_en && i_addr == sbow_pkg::OFS_DECEL_BOW_FIRST && !i_rd_en)
      ##1 !i_wr_en
      ##1 (i_rd_en && !i_wr_en && i_addr == sbow_pkg::OFS_DECEL_BOW_FIRST)
      |=> (o_rd_valid && o_rdata == {8'h00, $past(i_wdata[23:0], 3)}))
    else $error("bow field does not read back as written");

  direct_step_a: assert property (
    i_direct_mode |=> o_jerk_inc == $past(state_q.bow[i_bow_sel]))
    else $error("direct bow step wrong");

  conv_sat_a: assert property (
    (state_q.st == sbow_pkg::SBOW_DIV3 && div_done && (|div_quot[76:24]))
      |=> state_q.conv[$past(state_q.idx)] == 24'hffffff)
    else $error("oversized step not clipped");

  clk_store_a: assert property (
    (i_wr_en && i_addr == sbow_pkg::OFS_EXT_CLOCK_HERTZ) |=>
      state_q.clk_hz == $past(i_wdata[24:0]) && !o_conv_valid)
    else $error("clock rate register not written");

  clk_used_a: assert property (
    (state_q.st == sbow_pkg::SBOW_LOAD) |=>
      (state_q.f_snap == $past(state_q.clk_hz) && state_q.start))
    else $error("conversion not started with programmed clock rate");

  // ---------------------------------------------------------------------------
  // Register port and sequencing checks
  // ---------------------------------------------------------------------------
  rd_clock_a: assert property (
    (i_rd_en && i_addr == sbow_pkg::OFS_EXT_CLOCK_HERTZ) |=>
      (o_rd_valid && o_rdata == {7'h00, $past(state_q.clk_hz)}))
    else $error("clock rate register does not read back");

  rd_idle_a: assert property (
    !i_rd_en |=> !o_rd_valid)
    else $error("read valid without a read strobe");

  // A read sees the old field when a write shares its edge
  for (genvar g = 0; g < 4; g++) begin : g_bow_read
    bow_read_a: assert property (
      (i_rd_en && i_addr == sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(g)) |=>
        (o_rd_valid && o_rdata == {8'h00, $past(state_q.bow[g])}))
      else $error("bow register does not read back");
  end

  valid_hold_a: assert property (
    (o_conv_valid && !i_wr_en) |=> o_conv_valid)
    else $error("converted set lost its valid flag without a write");

  bow_stale_a: assert property (
    (i_wr_en && wr_hit[2]) |=> (!o_conv_valid && state_q.dirty))
    else $error("bow write did not mark the conversion stale");

  snap_hold_a: assert property (
    (state_q.st != sbow_pkg::SBOW_LOAD) |=> $stable(state_q.f_snap))
    else $error("clock rate snapshot moved during a division");

  conv_exact_a: assert property (
    (state_q.st == sbow_pkg::SBOW_DIV3 && div_done && !(|div_quot[76:24]))
      |=> state_q.conv[$past(state_q.idx)] == $past(div_quot[23:0]))
    else $error("in-range step not stored unchanged");

  idx_step_a: assert property (
    (state_q.st == sbow_pkg::SBOW_DIV3 && div_done) |=>
      (state_q.idx == $past(state_q.idx) + 2'h1 && state_q.st == sbow_pkg::SBOW_LOAD))
    else $error("conversion round did not move to the next bow");

  // One bow is a load cycle plus three passes of 79 cycles each
  bow_time_a: assert property (
    (state_q.st == sbow_pkg::SBOW_LOAD) |-> ##238 (state_q.st == sbow_pkg::SBOW_LOAD))
    else $error("bow conversion did not take 238 cycles");

  // Cycles since the last configuration write, saturating; used by checks only
  logic [9:0] wr_age_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_age_q <= '0;
    end else if (i_wr_en && (wr_hit[2] || i_addr == sbow_pkg::OFS_EXT_CLOCK_HERTZ)) begin
      wr_age_q <= '0;
    end else if (wr_age_q != 10'h3ff) begin
      wr_age_q <= wr_age_q + 10'h001;
    end
  end

  // A write always spoils the round it falls in, so a clean round of 952 cycles must follow
  valid_late_a: assert property (
    $rose(o_conv_valid) |-> wr_age_q >= 10'h3b8)
    else $error("conversion reported valid before a full clean round");

  round_c:  cover property ($rose(o_conv_valid));
  direct_c: cover property (i_direct_mode ##1 o_jerk_inc != 24'h000000);
  clkwr_c:  cover property (i_wr_en && i_addr == sbow_pkg::OFS_EXT_CLOCK_HERTZ);
  clip_c:   cover property (state_q.st == sbow_pkg::SBOW_DIV3 && div_done && (|div_quot[76:24]));

endmodule

// >>> sim/sbow_regs_tb_top.sv
`timescale 1ns/10ps
module sbow_regs_tb_top;

  // ---------------------------------------------------------------------------
  // Stimulus and observation signals
  // ---------------------------------------------------------------------------
  logic        i_clk;
  logic        i_rst_n;
  logic        i_wr_en;
  logic        i_rd_en;
  logic [6:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_direct_mode;
  logic [1:0]  i_bow_sel;
  logic [31:0] o_rdata;
  logic        o_rd_valid;
  logic [23:0] o_jerk_inc;
  logic        o_conv_valid;
  int          err_count;
  int          checks_done;
  logic [23:0] bows [4];

  sbow_regs sbow_regs_inst (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_wr_en       (i_wr_en),
    .i_rd_en       (i_rd_en),
    .i_addr        (i_addr),
    .i_wdata       (i_wdata),
    .i_direct_mode (i_direct_mode),
    .i_bow_sel     (i_bow_sel),
    .o_rdata       (o_rdata),
    .o_rd_valid    (o_rd_valid),
    .o_jerk_inc    (o_jerk_inc),
    .o_conv_valid  (o_conv_valid)
  );

  // ---------------------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Compare and count; four-state equality so an unknown never matches
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe, driven just after an edge
  task automatic reg_write(input logic [6:0] addr, input logic [31:0] data);
    @(posedge i_clk);
    #1;
    i_wr_en = 1'b1;
    i_addr  = addr;
    i_wdata = data;
    @(posedge i_clk);
    #1;
    i_wr_en = 1'b0;
  endtask

  // Read answers one cycle after the strobe edge, pulse looked at in that cycle
  task automatic reg_read(input logic [6:0] addr, input logic [31:0] exp);
    @(posedge i_clk);
    #1;
    i_rd_en = 1'b1;
    i_addr  = addr;
    @(posedge i_clk);
    #1;
    i_rd_en = 1'b0;
    check("rd_valid", {31'h0, o_rd_valid}, 32'h1);
    check("rdata", o_rdata, exp);
  endtask

  // Reference conversion: three truncating divisions, then saturate to 24 bits
  function automatic logic [23:0] ref_conv(input logic [23:0] b, input logic [24:0] f);
    logic [76:0] q;
    q = {b, 53'h0};
    q = q / {52'h0, f};
    q = q / {52'h0, f};
    q = q / {52'h0, f};
    return (q > 77'hffffff) ? 24'hffffff : q[23:0];
  endfunction

  // Select a bow and look at the step once the selection has landed
  task automatic check_jerk(input logic [1:0] sel, input logic [23:0] exp);
    @(posedge i_clk);
    #1;
    i_bow_sel = sel;
    repeat (2) @(posedge i_clk);
    #1;
    check("jerk_inc", {8'h0, o_jerk_inc}, {8'h0, exp});
  endtask

  // Program four bows plus clock rate, wait for a clean round, compare all
  task automatic conv_round(input logic [24:0] f);
    int n;
    reg_write(sbow_pkg::OFS_EXT_CLOCK_HERTZ, {7'h0, f});
    for (int k = 0; k < 4; k++) reg_write(sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(k), {8'h0, bows[k]});
    n = 0;
    while (o_conv_valid !== 1'b1 && n < 5000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("conv_valid", {31'h0, o_conv_valid}, 32'h1);
    for (int k = 0; k < 4; k++) check_jerk(2'(k), ref_conv(bows[k], f));
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Watchdog: whole sequence needs well under 30k cycles
  // ---------------------------------------------------------------------------
  initial begin
    #300000;
    err_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    err_count     = 0;
    checks_done   = 0;
    i_rst_n       = 1'b0;
    i_wr_en       = 1'b0;
    i_rd_en       = 1'b0;
    i_addr        = 7'h00;
    i_wdata       = 32'h0;
    i_direct_mode = 1'b1;
    i_bow_sel     = 2'h0;
    repeat (8) @(posedge i_clk);
    #1;
    check("rst_jerk", {8'h0, o_jerk_inc}, 32'h0);
    check("rst_conv", {31'h0, o_conv_valid}, 32'h0);
    i_rst_n = 1'b1;

    // Reset values of all five registers
    for (int k = 0; k < 4; k++) begin
      reg_read(sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(k), 32'h0);
    end
    reg_read(sbow_pkg::OFS_EXT_CLOCK_HERTZ, 32'h00f42400);

    // Bits above the field widths are dropped; unmapped place reads zero
    for (int k = 0; k < 4; k++) begin
      reg_write(sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(k), 32'hffffffff);
      reg_read(sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(k), 32'h00ffffff);
    end
    reg_write(sbow_pkg::OFS_EXT_CLOCK_HERTZ, 32'hffffffff);
    reg_read(sbow_pkg::OFS_EXT_CLOCK_HERTZ, 32'h01ffffff);
    reg_write(7'h2c, 32'h12345678);
    reg_read(7'h2c, 32'h0);
    reg_read(sbow_pkg::OFS_ACCEL_BOW_FIRST, 32'h00ffffff);

    // Direct form: each bow drives the step unchanged for its ramp segment
    bows = '{24'ha5a5a5, 24'h5a5a5a, 24'h000001, 24'hfedcba};
    for (int k = 0; k < 4; k++) begin
      reg_write(sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(k), {8'h0, bows[k]});
    end
    for (int k = 0; k < 4; k++) begin
      reg_read(sbow_pkg::OFS_ACCEL_BOW_FIRST + 7'(k), {8'h0, bows[k]});
    end
    for (int k = 0; k < 4; k++) check_jerk(2'(k), bows[k]);

    // Frequency form at range edges of both bow and clock rate
    i_direct_mode = 1'b0;
    bows = '{24'h000001, 24'h0186a0, 24'h800000, 24'hffffff};
    conv_round(25'h0401640);
    conv_round(25'h1e84800);
    // Far below the legal clock range, only to reach the clipping of oversized steps
    conv_round(25'h0000400);
    conv_round(25'h0f42400);

    // Back to direct form: converted copies must not leak through
    i_direct_mode = 1'b1;
    check_jerk(2'h3, 24'hffffff);
    print_verdict();
  end

endmodule
